// ===== core/slcs_pkg.sv
// Package with register map, field layout, reset values and link symbols for the link registers.
package slcs_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] SLCS_IDX_LINK_CTRL = 10'h200;
    localparam logic [9:0] SLCS_IDX_DEV_NUM = 10'h206;
    localparam logic [9:0] SLCS_IDX_EOF_SEL = 10'h207;
    localparam logic [9:0] SLCS_IDX_STATUS = 10'h208;
    localparam logic [9:0] SLCS_IDX_PWRDN = 10'h209;

    // Values after reset.
    localparam logic [7:0] SLCS_RST_DEV_NUM = 8'h00;
    localparam logic [1:0] SLCS_RST_EOF_SEL = 2'h0;
    localparam logic [1:0] SLCS_RST_PWRDN = 2'h0;
    localparam logic SLCS_RST_LINK_EN = 1'b0;

    // Field positions.
    localparam int SLCS_BIT_LINK_EN = 0;
    localparam int SLCS_BIT_LINK_UP = 6;
    localparam int SLCS_BIT_SYNC = 5;
    localparam int SLCS_BIT_REALIGNED = 4;
    localparam int SLCS_BIT_PHASE_SET = 3;
    localparam int SLCS_BIT_PLL_LOCK = 2;
    localparam int SLCS_BIT_PD_A = 0;
    localparam int SLCS_BIT_PD_B = 1;

    // Frame-end comma select codes.
    localparam logic [1:0] SLCS_EOF_K28_7 = 2'h0;
    localparam logic [1:0] SLCS_EOF_K28_1 = 2'h1;
    localparam logic [1:0] SLCS_EOF_K28_5 = 2'h2;

    // Control symbols, 8-bit value sent with the control flag high.
    localparam logic [7:0] SLCS_K28_0 = 8'h1C;
    localparam logic [7:0] SLCS_K28_1 = 8'h3C;
    localparam logic [7:0] SLCS_K28_3 = 8'h7C;
    localparam logic [7:0] SLCS_K28_4 = 8'h9C;
    localparam logic [7:0] SLCS_K28_5 = 8'hBC;
    localparam logic [7:0] SLCS_K28_7 = 8'hFC;

    // Index of the last alignment multiframe and of the one that carries the number.
    localparam logic [1:0] SLCS_ILA_LAST_MF = 2'h3;
    localparam logic [1:0] SLCS_ILA_CFG_MF = 2'h1;

    // Link framer states.
    typedef enum logic [3:0] {
        SLCS_ST_IDLE = 4'b0001,
        SLCS_ST_CGS = 4'b0010,
        SLCS_ST_ILA = 4'b0100,
        SLCS_ST_DATA = 4'b1000
    } slcs_state_e;

endpackage

// ===== core/slcs_regs.sv
// Link register bank with sample FIFO and two-lane frame builder.
// Behaviour
// - Lanes send the stored identifier in the second alignment multiframe.
// - Lane A sends the identifier and lane B the identifier plus one.
// - Identifier bit 0 is stored and read back as zero.
// - Comma select 0, 1 and 2 pick K28.7, K28.1 and K28.5; 3 is reserved.
// - The comma replaces a frame-end octet only when that octet repeats.
// - Status bit 6 reads one while the link is established.
// - Status bit 5 mirrors the sync input, zero while sync is requested.
// - Status bit 4 sets on a reference realignment while the link runs and clears on a written one.
// - Status bit 3 sets on the first reference event after enable; a written one clears it.
// - Status bit 2 reads one while the serializer PLL is locked and the subsystem is not powered down.
// - Bits 0 and 1 power down converter A or B with their bound digital channels.
// - With both converters down the link subsystem, PLL and multiframe clock stop.
// - With both channels on lane A and channel B down, lane A keeps running.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// Synchronous FIFO with valid and ready on both sides.
module slcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Filling side.
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side.
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;

    // Handshakes on both sides.
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_q];

    // Occupancy after this cycle's push and pop.
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = CW'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = CW'(count_q - 1'b1);
        end
    end

    // Storage array write.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers, count and the full and empty flags.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
            end
            count_q <= count_d;
            in_ready_o <= (count_d != CW'(DEPTH));
            out_valid_o <= (count_d != '0);
        end
    end
endmodule

// Register bank on Avalon-MM and the lane frame builder it steers.
module slcs_regs
    import slcs_pkg::*;
#(
    parameter int FRAME_OCTETS = 2,
    parameter int MF_FRAMES = 4,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Avalon-MM slave, word addressed.
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Link side status and reference inputs.
    input wire logic sync_n_i,
    input wire logic pll_locked_i,
    input wire logic sysref_realign_i,
    input wire logic sysref_event_i,
    input wire logic [1:0] digital_channel_binding_i,
    input wire logic shared_lane_mode_i,
    // Sample stream in, low octet for channel A and high octet for channel B.
    input wire logic in_valid_i,
    input wire logic [15:0] in_data_i,
    output logic in_ready_o,
    // Lane symbols out, octet with control flag.
    output logic [7:0] lane_a_data_o,
    output logic lane_a_k_o,
    output logic lane_a_valid_o,
    output logic [7:0] lane_b_data_o,
    output logic lane_b_k_o,
    output logic lane_b_valid_o,
    // Power-down controls.
    output logic channel_a_powerdown_o,
    output logic channel_b_powerdown_o,
    output logic digital_a_powerdown_o,
    output logic digital_b_powerdown_o,
    output logic subsystem_powerdown_o,
    output logic serial_link_enable_o
);
    localparam int PW = $clog2(FRAME_OCTETS * MF_FRAMES);
    localparam int OW = (FRAME_OCTETS > 1) ? $clog2(FRAME_OCTETS) : 1;

    logic [7:0] sequence_device_number_q;
    logic [1:0] frame_end_comma_select_q;
    logic channel_a_powerdown_q;
    logic channel_b_powerdown_q;
    logic serial_link_enable_q;
    logic realigned_flag_q;
    logic multiframe_phase_set_flag_q;
    logic phase_armed_q;
    logic bus_req;
    logic bus_ack;
    logic byte0_we;
    logic [7:0] read_value;
    logic [7:0] status_value;
    logic link_run;
    slcs_state_e state_q;
    logic [PW-1:0] pos_q;
    logic [OW-1:0] octet_q;
    logic [1:0] ila_mf_q;
    logic phase_q;
    logic frame_end;
    logic mf_end;
    logic [7:0] prev_a_q;
    logic [7:0] prev_b_q;
    logic fifo_valid;
    logic fifo_pop;
    logic [15:0] fifo_data;
    logic [7:0] raw_a;
    logic [7:0] raw_b;
    logic [7:0] eof_char;
    logic [8:0] sym_a;
    logic [8:0] sym_b;

    // An access completes at the edge where waitrequest is low.
    assign bus_req = avs_read_i || avs_write_i;
    assign bus_ack = bus_req && !avs_waitrequest_o;
    assign byte0_we = bus_ack && avs_write_i && avs_byteenable_i[0];

    // Live status word; reserved bits read zero.
    always_comb begin
        status_value = 8'h00;
        status_value[SLCS_BIT_LINK_UP] = (state_q == SLCS_ST_DATA);
        status_value[SLCS_BIT_SYNC] = sync_n_i;
        status_value[SLCS_BIT_REALIGNED] = realigned_flag_q;
        status_value[SLCS_BIT_PHASE_SET] = multiframe_phase_set_flag_q;
        status_value[SLCS_BIT_PLL_LOCK] = pll_locked_i && !subsystem_powerdown_o;
    end

    // Read multiplexer; unmapped indices read zero.
    always_comb begin
        case (avs_address_i)
            SLCS_IDX_LINK_CTRL: read_value = {7'h00, serial_link_enable_q};
            SLCS_IDX_DEV_NUM: read_value = {sequence_device_number_q[7:1], 1'b0};
            SLCS_IDX_EOF_SEL: read_value = {6'h00, frame_end_comma_select_q};
            SLCS_IDX_STATUS: read_value = status_value;
            SLCS_IDX_PWRDN: read_value = {6'h00, channel_b_powerdown_q, channel_a_powerdown_q};
            default: read_value = 8'h00;
        endcase
    end

    // One wait state per access.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            if (bus_req && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= {24'h00_0000, read_value};
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    // Software-written configuration.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_link_enable_q <= SLCS_RST_LINK_EN;
            sequence_device_number_q <= SLCS_RST_DEV_NUM;
            frame_end_comma_select_q <= SLCS_RST_EOF_SEL;
            channel_a_powerdown_q <= SLCS_RST_PWRDN[SLCS_BIT_PD_A];
            channel_b_powerdown_q <= SLCS_RST_PWRDN[SLCS_BIT_PD_B];
        end else if (byte0_we) begin
            case (avs_address_i)
                SLCS_IDX_LINK_CTRL: begin
                    serial_link_enable_q <= avs_writedata_i[SLCS_BIT_LINK_EN];
                end
                SLCS_IDX_DEV_NUM: begin
                    sequence_device_number_q <= {avs_writedata_i[7:1], 1'b0};
                end
                SLCS_IDX_EOF_SEL: begin
                    frame_end_comma_select_q <= avs_writedata_i[1:0];
                end
                SLCS_IDX_PWRDN: begin
                    channel_a_powerdown_q <= avs_writedata_i[SLCS_BIT_PD_A];
                    channel_b_powerdown_q <= avs_writedata_i[SLCS_BIT_PD_B];
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky alignment flags; a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            realigned_flag_q <= 1'b0;
            multiframe_phase_set_flag_q <= 1'b0;
            phase_armed_q <= 1'b0;
        end else begin
            if (sysref_realign_i && link_run) begin
                realigned_flag_q <= 1'b1;
            end else if (byte0_we && avs_address_i == SLCS_IDX_STATUS &&
                avs_writedata_i[SLCS_BIT_REALIGNED]) begin
                realigned_flag_q <= 1'b0;
            end
            if (sysref_event_i && phase_armed_q) begin
                multiframe_phase_set_flag_q <= 1'b1;
            end else if (byte0_we && avs_address_i == SLCS_IDX_STATUS &&
                avs_writedata_i[SLCS_BIT_PHASE_SET]) begin
                multiframe_phase_set_flag_q <= 1'b0;
            end
            // Armed while the link is stopped; the first reference event once it runs disarms it.
            if (!link_run) begin
                phase_armed_q <= 1'b1;
            end else if (sysref_event_i) begin
                phase_armed_q <= 1'b0;
            end
        end
    end

    // Power-down fan-out.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            channel_a_powerdown_o <= 1'b0;
            channel_b_powerdown_o <= 1'b0;
            digital_a_powerdown_o <= 1'b0;
            digital_b_powerdown_o <= 1'b0;
            subsystem_powerdown_o <= 1'b0;
            serial_link_enable_o <= 1'b0;
        end else begin
            channel_a_powerdown_o <= channel_a_powerdown_q;
            channel_b_powerdown_o <= channel_b_powerdown_q;
            digital_a_powerdown_o <= digital_channel_binding_i[0] ?
                channel_b_powerdown_q : channel_a_powerdown_q;
            digital_b_powerdown_o <= digital_channel_binding_i[1] ?
                channel_b_powerdown_q : channel_a_powerdown_q;
            subsystem_powerdown_o <= channel_a_powerdown_q && channel_b_powerdown_q;
            serial_link_enable_o <= serial_link_enable_q;
        end
    end

    // The link runs only when enabled and not wholly powered down.
    assign link_run = serial_link_enable_q && !subsystem_powerdown_o;

    // Sample FIFO.
    slcs_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(in_valid_i),
        .in_data_i(in_data_i),
        .in_ready_o(in_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(fifo_pop)
    );

    // Frame and multiframe position.
    assign frame_end = (octet_q == OW'(FRAME_OCTETS - 1));
    assign mf_end = (pos_q == PW'(FRAME_OCTETS * MF_FRAMES - 1));

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_q <= '0;
            octet_q <= '0;
        end else if (!link_run) begin
            pos_q <= '0;
            octet_q <= '0;
        end else begin
            pos_q <= mf_end ? '0 : PW'(pos_q + 1'b1);
            octet_q <= frame_end ? '0 : OW'(octet_q + 1'b1);
        end
    end

    // Framer: comma sync, four-multiframe alignment sequence, then data.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= SLCS_ST_IDLE;
            ila_mf_q <= 2'h0;
        end else begin
            case (state_q)
                SLCS_ST_IDLE: begin
                    if (link_run) begin
                        state_q <= SLCS_ST_CGS;
                    end
                end
                SLCS_ST_CGS: begin
                    if (!link_run) begin
                        state_q <= SLCS_ST_IDLE;
                    end else if (sync_n_i && mf_end) begin
                        state_q <= SLCS_ST_ILA;
                        ila_mf_q <= 2'h0;
                    end
                end
                SLCS_ST_ILA: begin
                    if (!link_run) begin
                        state_q <= SLCS_ST_IDLE;
                    end else if (!sync_n_i) begin
                        state_q <= SLCS_ST_CGS;
                    end else if (mf_end) begin
                        if (ila_mf_q == SLCS_ILA_LAST_MF) begin
                            state_q <= SLCS_ST_DATA;
                        end
                        ila_mf_q <= 2'(ila_mf_q + 1'b1);
                    end
                end
                SLCS_ST_DATA: begin
                    if (!link_run) begin
                        state_q <= SLCS_ST_IDLE;
                    end else if (!sync_n_i) begin
                        state_q <= SLCS_ST_CGS;
                    end
                end
                default: begin
                    state_q <= SLCS_ST_IDLE;
                end
            endcase
        end
    end

    // In shared mode lane A sends both octets of a word on two cycles.
    assign fifo_pop = (state_q == SLCS_ST_DATA) && fifo_valid &&
        (!shared_lane_mode_i || phase_q);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= 1'b0;
        end else if (state_q != SLCS_ST_DATA || !shared_lane_mode_i) begin
            phase_q <= 1'b0;
        end else if (fifo_valid) begin
            phase_q <= !phase_q;
        end
    end

    // Raw data octets; an empty FIFO sends zero.
    assign raw_a = !fifo_valid ? 8'h00 :
        (shared_lane_mode_i && phase_q) ? fifo_data[15:8] : fifo_data[7:0];
    assign raw_b = fifo_valid ? fifo_data[15:8] : 8'h00;

    // Frame-end comma chosen by the select field; the reserved code falls back to K28.7.
    always_comb begin
        case (frame_end_comma_select_q)
            SLCS_EOF_K28_1: eof_char = SLCS_K28_1;
            SLCS_EOF_K28_5: eof_char = SLCS_K28_5;
            SLCS_EOF_K28_7: eof_char = SLCS_K28_7;
            default: eof_char = SLCS_K28_7;
        endcase
    end

    // Symbol for one lane, {control, octet}, from framer state and position.
    function automatic logic [8:0] lane_symbol(input slcs_state_e st, input logic [7:0] raw,
        input logic [7:0] prev, input logic [7:0] num);
        logic [8:0] sym;
        sym = {1'b0, raw};
        case (st)
            SLCS_ST_CGS: begin
                sym = {1'b1, SLCS_K28_5};
            end
            SLCS_ST_ILA: begin
                sym = {1'b0, 8'(pos_q)};
                if (pos_q == '0) begin
                    sym = {1'b1, SLCS_K28_0};
                end else if (mf_end) begin
                    sym = {1'b1, SLCS_K28_3};
                end else if (ila_mf_q == SLCS_ILA_CFG_MF && pos_q == PW'(1)) begin
                    sym = {1'b1, SLCS_K28_4};
                end else if (ila_mf_q == SLCS_ILA_CFG_MF && pos_q == PW'(2)) begin
                    sym = {1'b0, num};
                end
            end
            SLCS_ST_DATA: begin
                // Replace only a repeated frame-end octet, multiframe ends with K28.3.
                if (frame_end && raw == prev) begin
                    sym = mf_end ? {1'b1, SLCS_K28_3} : {1'b1, eof_char};
                end
            end
            default: begin
                sym = 9'h000;
            end
        endcase
        return sym;
    endfunction

    // A process, so that it wakes on the counters the function reads.
    always_comb begin
        sym_a = lane_symbol(state_q, raw_a, prev_a_q, sequence_device_number_q);
        sym_b = lane_symbol(state_q, raw_b, prev_b_q,
            8'(sequence_device_number_q + 8'h01));
    end

    // Registered lane outputs and last frame-end octets.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lane_a_data_o <= 8'h00;
            lane_a_k_o <= 1'b0;
            lane_a_valid_o <= 1'b0;
            lane_b_data_o <= 8'h00;
            lane_b_k_o <= 1'b0;
            lane_b_valid_o <= 1'b0;
            prev_a_q <= 8'h00;
            prev_b_q <= 8'h00;
        end else begin
            lane_a_data_o <= sym_a[7:0];
            lane_a_k_o <= sym_a[8];
            lane_a_valid_o <= (state_q != SLCS_ST_IDLE) && link_run;
            lane_b_data_o <= sym_b[7:0];
            lane_b_k_o <= sym_b[8];
            lane_b_valid_o <= (state_q != SLCS_ST_IDLE) && link_run && !shared_lane_mode_i;
            if (state_q == SLCS_ST_DATA && frame_end) begin
                prev_a_q <= raw_a;
                prev_b_q <= raw_b;
            end
        end
    end
endmodule

// ===== dv/slcs_regs_props.sv
// Checker for the link register bank, seen only through its ports.
`timescale 1ns/10ps
module slcs_props
    import slcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Register bus.
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Link status inputs and outputs.
    input wire logic sync_n_i,
    input wire logic pll_locked_i,
    input wire logic [7:0] lane_a_data_o,
    input wire logic lane_a_k_o,
    input wire logic [7:0] lane_b_data_o,
    input wire logic lane_b_valid_o,
    input wire logic channel_a_powerdown_o,
    input wire logic channel_b_powerdown_o,
    input wire logic subsystem_powerdown_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic rs;
    logic rn;
    // Completed reads of the status and number registers.
    assign rs = avs_read_i && !avs_waitrequest_o && avs_address_i == SLCS_IDX_STATUS;
    assign rn = avs_read_i && !avs_waitrequest_o && avs_address_i == SLCS_IDX_DEV_NUM;
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus answer missing");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low too long");
    a_number_even: assert property (rn |-> !avs_readdata_o[0])
        else $error("odd number read");
    a_sync_mirror: assert property (rs && $stable(sync_n_i) |->
        avs_readdata_o[5] == sync_n_i) else $error("sync bit wrong");
    a_pll_mirror: assert property (rs && $stable(pll_locked_i) &&
        $stable(subsystem_powerdown_o) |->
        avs_readdata_o[2] == (pll_locked_i && !subsystem_powerdown_o)) else $error("lock bit wrong");
    a_status_reserved: assert property (rs |-> avs_readdata_o[31:7] == '0 &&
        avs_readdata_o[1:0] == '0) else $error("reserved status bits set");
    a_subsys_down: assert property (subsystem_powerdown_o ==
        (channel_a_powerdown_o && channel_b_powerdown_o)) else $error("subsystem down wrong");
    a_lane_number: assert property (lane_a_k_o && lane_a_data_o == SLCS_K28_4 &&
        lane_b_valid_o |=> !lane_a_data_o[0] && lane_b_data_o == 8'(lane_a_data_o + 8'h01))
        else $error("lane number wrong");
endmodule
bind slcs_regs slcs_props slcs_props_i (.*);

// ===== dv/slcs_regs_tb_top.sv
// Testbench for the link register bank.
`timescale 1ns/10ps
module slcs_regs_tb_top
    import slcs_pkg::*;
;
    logic clock_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, rdat;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic avs_waitrequest_o, sync_n_i, pll_locked_i = 1'b1, sysref_realign_i = 1'b0;
    logic sysref_event_i = 1'b0, shared_lane_mode_i = 1'b0, in_valid_i = 1'b0, rsy = 1'b0;
    logic [1:0] digital_channel_binding_i = 2'h0;
    logic [15:0] in_data_i = 16'h0000;
    logic in_ready_o, lane_a_k_o, lane_a_valid_o, lane_b_k_o, lane_b_valid_o, pk = 1'b0;
    logic [7:0] lane_a_data_o, lane_b_data_o, lk, ida, idb;
    logic channel_a_powerdown_o, channel_b_powerdown_o, digital_a_powerdown_o;
    logic digital_b_powerdown_o, subsystem_powerdown_o, serial_link_enable_o;
    logic [7:0] tbl [4] = '{SLCS_K28_7, SLCS_K28_1, SLCS_K28_5, SLCS_K28_7};
    int fail_count = 0, total_checks = 0;
    slcs_regs #(.FIFO_DEPTH(32)) slcs_regs_i (.*);
    slcs_rx_model #(.HOLD(4)) slcs_rx_model_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .lane_a_data_i(lane_a_data_o), .lane_a_k_i(lane_a_k_o), .resync_i(rsy), .sync_n_o(sync_n_i));
    initial forever #50 clock_i = ~clock_i;
    // Captures lane numbers after K28.4 and the last lane A comma.
    always @(posedge clock_i) begin
        if (pk) begin
            ida <= lane_a_data_o;
            idb <= lane_b_data_o;
        end
        pk <= lane_a_valid_o && lane_a_k_o && lane_a_data_o == SLCS_K28_4;
        if (lane_a_valid_o && lane_a_k_o && !(lane_a_data_o inside {8'h1C, 8'h7C, 8'h9C}))
            lk <= lane_a_data_o;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One bus access, held until waitrequest is sampled low.
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        avs_address_i <= a;
        avs_writedata_i <= 32'(d);
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rdat, {24'h00_0000, e});
    endtask
    task automatic up();
        rdat = '0;
        repeat (40) if (rdat[6] !== 1'b1) acc(1'b0, SLCS_IDX_STATUS, 8'h00);
    endtask
    // Fills the FIFO while the link is stopped.
    task automatic fill();
        int n;
        n = 0;
        in_valid_i <= 1'b1;
        repeat (40) begin
            @(posedge clock_i);
            if (in_ready_o === 1'b1) begin
                n++;
                in_data_i <= in_data_i + 16'h0101;
            end
        end
        in_valid_i <= 1'b0;
        chk(n, 32);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #5000000;
        fail_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rd(SLCS_IDX_EOF_SEL, 8'h00);
        rd(10'h201, 8'h00);
        acc(1'b1, SLCS_IDX_DEV_NUM, 8'h35);
        rd(SLCS_IDX_DEV_NUM, 8'h34);
        avs_byteenable_i <= 4'hE;
        acc(1'b1, SLCS_IDX_DEV_NUM, 8'h10);
        avs_byteenable_i <= 4'hF;
        rd(SLCS_IDX_DEV_NUM, 8'h34);
        for (int i = 0; i < 16; i++) begin
            digital_channel_binding_i <= i[3:2];
            acc(1'b1, SLCS_IDX_PWRDN, {6'h00, i[1:0]});
            @(posedge clock_i);
            chk({channel_a_powerdown_o, channel_b_powerdown_o, digital_a_powerdown_o,
                digital_b_powerdown_o, subsystem_powerdown_o},
                {i[0], i[1], i[2] ? i[1] : i[0], i[3] ? i[1] : i[0], i[0] & i[1]});
            rd(SLCS_IDX_STATUS, (i[1:0] == 2'h3) ? 8'h00 : 8'h04);
        end
        acc(1'b1, SLCS_IDX_PWRDN, 8'h00);
        pll_locked_i <= 1'b0;
        rd(SLCS_IDX_STATUS, 8'h00);
        pll_locked_i <= 1'b1;
        $display("registers done");
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, SLCS_IDX_LINK_CTRL, 8'h00);
            acc(1'b1, SLCS_IDX_EOF_SEL, s[7:0]);
            rd(SLCS_IDX_EOF_SEL, s[7:0]);
            if (s == 0) fill();
            acc(1'b1, SLCS_IDX_LINK_CTRL, 8'h01);
            up();
            chk({serial_link_enable_o, rdat[7:0]}, 9'h164);
            if (s == 0) chk({ida, idb}, 16'h3435);
            repeat (64) @(posedge clock_i);
            chk(lk, tbl[s]);
        end
        $display("link done");
        sysref_event_i <= 1'b1;
        @(posedge clock_i);
        sysref_event_i <= 1'b0;
        rd(SLCS_IDX_STATUS, 8'h6C);
        sysref_realign_i <= 1'b1;
        @(posedge clock_i);
        sysref_realign_i <= 1'b0;
        rd(SLCS_IDX_STATUS, 8'h7C);
        acc(1'b1, SLCS_IDX_STATUS, 8'hE4);
        rd(SLCS_IDX_STATUS, 8'h7C);
        acc(1'b1, SLCS_IDX_STATUS, 8'h18);
        rd(SLCS_IDX_STATUS, 8'h64);
        rsy <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(SLCS_IDX_STATUS, 8'h04);
        rsy <= 1'b0;
        acc(1'b1, SLCS_IDX_LINK_CTRL, 8'h00);
        digital_channel_binding_i <= 2'h2;
        shared_lane_mode_i <= 1'b1;
        acc(1'b1, SLCS_IDX_PWRDN, 8'h02);
        acc(1'b1, SLCS_IDX_LINK_CTRL, 8'h01);
        up();
        chk({rdat[6], lane_a_valid_o, lane_b_valid_o}, 3'b110);
        $display("status done");
        results();
    end
endmodule

// ===== dv/slcs_rx_model.sv
// Receiver model that requests sync until enough K28.5 symbols arrive.
`timescale 1ns/10ps
module slcs_rx_model #(
    parameter int HOLD = 4
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [7:0] lane_a_data_i,
    input wire logic lane_a_k_i,
    input wire logic resync_i,
    output logic sync_n_o
);
    int cnt;
    // A broken run of commas restarts the count; resync_i forces a new request.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 0;
            sync_n_o <= 1'b0;
        end else if (resync_i || !(lane_a_k_i && lane_a_data_i == 8'hBC)) begin
            cnt <= 0;
            sync_n_o <= sync_n_o && !resync_i;
        end else begin
            cnt <= cnt + 1;
            sync_n_o <= sync_n_o || cnt >= HOLD;
        end
    end
endmodule
